// *** hw/printer_attach_pkg.sv ***
package printer_attach_pkg;

  // ---------------------------------------------------------------------------
  // Clocking and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ           = 40000000;
  localparam int PHASE_COUNT      = 9;
  localparam logic [3:0] PHASE_LAST  = 4'h8;
  localparam logic [3:0] PHASE_5C    = 4'h5;
  localparam logic [3:0] PHASE_6     = 4'h6;
  localparam logic [3:0] PHASE_7B    = 4'h7;
  localparam int START_PULSE_US   = 2000;
  localparam int HORIZ_TIMEOUT_US = 35000;
  localparam int START_PULSE_CYC  = (START_PULSE_US * (CLK_HZ / 1000000));
  localparam int HORIZ_TIMEOUT_CYC = (HORIZ_TIMEOUT_US * (CLK_HZ / 1000000));
  localparam int TIMER_W          = 21;

  // ---------------------------------------------------------------------------
  // Instruction fields
  // ---------------------------------------------------------------------------
  localparam int PRINT_MODE_BIT    = 7;
  localparam logic [7:0] DEVICE_ADDR_DEFAULT = 8'h0E;
  localparam int MOD_W             = 3;
  localparam logic [2:0] MOD_PRINT     = 3'h0;
  localparam logic [2:0] MOD_ELEM_RET  = 3'h1;
  localparam logic [2:0] MOD_TAB_RIGHT = 3'h2;
  localparam logic [2:0] MOD_TAB_LEFT  = 3'h3;
  localparam logic [2:0] MOD_MAX       = 3'h3;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS     = 4'h0;
  localparam logic [3:0] ADDR_MASK       = 4'h1;
  localparam logic [3:0] ADDR_STATE      = 4'h2;
  localparam logic [3:0] ADDR_DEVADDR    = 4'h3;
  localparam logic [31:0] READ_UNMAPPED  = 32'h00000000;
  localparam int EVT_W         = 4;
  localparam int EVT_ACCEPT    = 0;
  localparam int EVT_REJECT    = 1;
  localparam int EVT_HCHECK    = 2;
  localparam int EVT_STEP      = 3;

  typedef enum logic [3:0] {
    STEP_IDLE  = 4'b0001,
    STEP_WRISE = 4'b0010,
    STEP_WFALL = 4'b0100,
    STEP_READY = 4'b1000
  } step_e;

  typedef struct packed {
    logic       startIo;
    logic       senseIo;
    logic [7:0] deviceAddr;
    logic [2:0] modifier;
    logic [7:0] controlCode;
    logic       parityOk;
  } io_request_s;

  typedef struct packed {
    logic [7:0] status1;
    logic [7:0] status2;
  } sense_bytes_s;

endpackage

// *** hw/printer_attachment_start_and_stepper.sv ***
module printer_attachment_start_and_stepper (
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire logic [3:0]                        clockPhase,
  input  wire logic                              secondInstrCycle,
  input  wire logic                              thirdInstrCycle,
  input  wire logic                              firstExecuteCycle,
  input  wire logic                              laterExecuteCycle,
  input  wire printer_attach_pkg::io_request_s   ioRequest,
  input  wire printer_attach_pkg::sense_bytes_s  senseLow,
  input  wire printer_attach_pkg::sense_bytes_s  senseHigh,
  input  wire logic                              senseUpperPair,
  input  wire logic                              commandSteal,
  input  wire logic                              stepperEmitter,
  input  wire logic                              matrixCounterTr1,
  output logic                                   conditionAccepted,
  output logic                                   conditionValid,
  output logic [7:0]                             inboundBus,
  output logic                                   inboundValid,
  output logic                                   biDirectionalMode,
  output logic                                   setCommandRequest,
  output logic                                   commandRequest,
  output logic                                   priorityRequestBit5,
  output logic                                   stepperGo,
  output logic                                   stepperStartPulse,
  output logic                                   horizontalCommand,
  output logic                                   horizontalLeftCommand,
  output logic                                   elementReturn,
  output logic                                   horizontalCheckInterlock,
  output logic                                   horizontalCycleCheck,
  output logic                                   stepperPhaseATrigger,
  output logic                                   stepperPhaseBTrigger,
  input  wire logic [3:0]                        avsAddress,
  input  wire logic                              avsRead,
  input  wire logic                              avsWrite,
  input  wire logic [31:0]                       avsWritedata,
  output logic [31:0]                            avsReaddata,
  output logic                                   avsWaitrequest,
  output logic                                   irq
);
  import printer_attach_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0]        emitSync;
  logic [1:0]        matrixSync;
  logic              emitPrev;
  logic              stepperRise;
  logic              stepperFall;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      emitSync   <= 2'h0;
      matrixSync <= 2'h0;
      emitPrev   <= 1'b0;
    end else begin
      emitSync   <= {emitSync[0], stepperEmitter};
      matrixSync <= {matrixSync[0], matrixCounterTr1};
      emitPrev   <= emitSync[1];
    end
  end

  assign stepperRise = emitSync[1] & ~emitPrev;
  assign stepperFall = ~emitSync[1] & emitPrev;

  // ---------------------------------------------------------------------------
  // Start I/O acceptance
  // ---------------------------------------------------------------------------
  logic [7:0]        deviceAddress;
  logic              addrMatch;
  logic              modValid;
  logic              accept;
  logic              acceptedHeld;
  logic [MOD_W-1:0]  heldModifier;

  assign addrMatch = (ioRequest.deviceAddr == deviceAddress);
  assign modValid  = (ioRequest.modifier <= MOD_MAX);
  assign accept    = ioRequest.startIo & secondInstrCycle & ioRequest.parityOk
                   & addrMatch & modValid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conditionAccepted <= 1'b0;
      conditionValid    <= 1'b0;
    end else if (ioRequest.startIo && secondInstrCycle) begin
      conditionAccepted <= accept;
      conditionValid    <= 1'b1;
    end else begin
      conditionAccepted <= 1'b0;
      conditionValid    <= 1'b0;
    end
  end

  // Without acceptance the processor repeats the cycles, so nothing is held.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acceptedHeld <= 1'b0;
      heldModifier <= MOD_PRINT;
    end else if (accept) begin
      acceptedHeld <= 1'b1;
      heldModifier <= ioRequest.modifier;
    end else if (thirdInstrCycle && clockPhase == PHASE_LAST) begin
      acceptedHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      biDirectionalMode <= 1'b0;
    end else if (acceptedHeld && thirdInstrCycle && clockPhase == PHASE_5C) begin
      biDirectionalMode <= ioRequest.controlCode[PRINT_MODE_BIT];
    end
  end

  assign setCommandRequest = acceptedHeld & thirdInstrCycle;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      commandRequest <= 1'b0;
    end else if (setCommandRequest && clockPhase == PHASE_7B) begin
      commandRequest <= 1'b1;
    end else if (commandSteal) begin
      commandRequest <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      priorityRequestBit5 <= 1'b0;
    end else if (clockPhase == PHASE_6) begin
      priorityRequestBit5 <= commandRequest;
    end
  end

  // ---------------------------------------------------------------------------
  // Sense status gating
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inboundBus   <= 8'h00;
      inboundValid <= 1'b0;
    end else if (ioRequest.senseIo && firstExecuteCycle) begin
      inboundBus   <= senseUpperPair ? senseHigh.status1 : senseLow.status1;
      inboundValid <= 1'b1;
    end else if (ioRequest.senseIo && laterExecuteCycle) begin
      inboundBus   <= senseUpperPair ? senseHigh.status2 : senseLow.status2;
      inboundValid <= 1'b1;
    end else begin
      inboundBus   <= 8'h00;
      inboundValid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Command steal: motion latches and single-shots
  // ---------------------------------------------------------------------------
  logic              horizMotion;
  logic              fireMotion;
  logic              leftward;
  logic [TIMER_W-1:0] startTimer;
  logic [TIMER_W-1:0] horizTimer;

  assign horizMotion = (heldModifier != MOD_PRINT);
  assign fireMotion  = commandSteal & (clockPhase == PHASE_6) & horizMotion;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      elementReturn         <= 1'b0;
      horizontalCommand     <= 1'b0;
      horizontalLeftCommand <= 1'b0;
      leftward              <= 1'b0;
    end else if (commandSteal && clockPhase == PHASE_5C) begin
      elementReturn         <= (heldModifier == MOD_ELEM_RET);
      horizontalCommand     <= horizMotion;
      horizontalLeftCommand <= (heldModifier == MOD_ELEM_RET)
                             | (heldModifier == MOD_TAB_LEFT);
      leftward              <= (heldModifier != MOD_TAB_RIGHT);
    end else if (!commandSteal && !horizontalCheckInterlock && !stepperGo) begin
      horizontalCommand     <= 1'b0;
      horizontalLeftCommand <= 1'b0;
      elementReturn         <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stepperGo  <= 1'b0;
      startTimer <= '0;
    end else if (fireMotion) begin
      stepperGo  <= 1'b1;
      startTimer <= TIMER_W'(START_PULSE_CYC);
    end else begin
      if (startTimer != '0) begin
        startTimer <= startTimer - TIMER_W'(1);
      end
      if (matrixSync[1] || horizontalCycleCheck) begin
        stepperGo <= 1'b0;
      end
    end
  end

  assign stepperStartPulse = (startTimer != '0);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      horizontalCheckInterlock <= 1'b0;
      horizTimer               <= '0;
    end else if (fireMotion) begin
      horizontalCheckInterlock <= 1'b1;
      horizTimer               <= TIMER_W'(HORIZ_TIMEOUT_CYC);
    end else begin
      if (horizTimer != '0) begin
        horizTimer <= horizTimer - TIMER_W'(1);
      end
      if (matrixSync[1]) begin
        horizontalCheckInterlock <= 1'b0;
      end
    end
  end

  // A timer running out with the interlock still set is a cycle check.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      horizontalCycleCheck <= 1'b0;
    end else if (fireMotion) begin
      horizontalCycleCheck <= 1'b0;
    end else if (horizTimer == TIMER_W'(1) && horizontalCheckInterlock
                 && !matrixSync[1]) begin
      horizontalCycleCheck <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Stepper trigger sequencer
  // ---------------------------------------------------------------------------
  step_e             stepState;
  step_e             next_stepState;
  logic              advance;
  logic              startEdge;
  logic              stepPulseDly;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stepPulseDly <= 1'b0;
    end else begin
      stepPulseDly <= fireMotion;
    end
  end

  assign startEdge = stepPulseDly;
  assign advance   = stepperGo & ((stepState == STEP_IDLE && startEdge)
                   || stepState == STEP_READY);

  always_comb begin
    next_stepState = stepState;
    case (stepState)
      STEP_IDLE: begin
        if (advance) begin
          next_stepState = STEP_WRISE;
        end
      end
      STEP_WRISE: begin
        if (stepperRise) begin
          next_stepState = STEP_WFALL;
        end
      end
      STEP_WFALL: begin
        if (stepperFall) begin
          next_stepState = STEP_READY;
        end
      end
      STEP_READY: begin
        if (advance) begin
          next_stepState = STEP_WRISE;
        end else if (!stepperGo) begin
          next_stepState = STEP_IDLE;
        end
      end
      default: begin
        next_stepState = STEP_IDLE;
      end
    endcase
    if (!stepperGo) begin
      next_stepState = STEP_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stepState <= STEP_IDLE;
    end else begin
      stepState <= next_stepState;
    end
  end

  // Gray order: off/off, A, AB, B forward; reverse walks the same ring backward.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stepperPhaseATrigger <= 1'b0;
      stepperPhaseBTrigger <= 1'b0;
    end else if (advance) begin
      if (stepperPhaseATrigger ^ stepperPhaseBTrigger ^ leftward) begin
        stepperPhaseBTrigger <= ~stepperPhaseBTrigger;
      end else begin
        stepperPhaseATrigger <= ~stepperPhaseATrigger;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Avalon-MM slave and interrupts
  // ---------------------------------------------------------------------------
  logic [EVT_W-1:0]  eventStatus;
  logic [EVT_W-1:0]  eventMask;
  logic [EVT_W-1:0]  eventSet;
  logic              checkPrev;
  logic              busWrite;

  assign eventSet = {advance, horizontalCycleCheck & ~checkPrev,
                     conditionValid & ~conditionAccepted, conditionAccepted};
  assign busWrite = avsWrite & ~avsWaitrequest;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      checkPrev <= 1'b0;
    end else begin
      checkPrev <= horizontalCycleCheck;
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eventStatus <= '0;
    end else if (busWrite && avsAddress == ADDR_STATUS) begin
      eventStatus <= (eventStatus & ~avsWritedata[EVT_W-1:0]) | eventSet;
    end else begin
      eventStatus <= eventStatus | eventSet;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eventMask     <= '0;
      deviceAddress <= DEVICE_ADDR_DEFAULT;
    end else if (busWrite && avsAddress == ADDR_MASK) begin
      eventMask <= avsWritedata[EVT_W-1:0];
    end else if (busWrite && avsAddress == ADDR_DEVADDR) begin
      deviceAddress <= avsWritedata[7:0];
    end
  end

  // Reads answer one cycle after the request; writes take effect in that same later cycle, once avsWaitrequest is low.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= READ_UNMAPPED;
    end else if ((avsRead || avsWrite) && avsWaitrequest) begin
      avsWaitrequest <= 1'b0;
      case (avsAddress)
        ADDR_STATUS:  avsReaddata <= {28'h0000000, eventStatus};
        ADDR_MASK:    avsReaddata <= {28'h0000000, eventMask};
        ADDR_STATE:   avsReaddata <= {20'h00000, stepState, stepperPhaseBTrigger,
                                      stepperPhaseATrigger, horizontalCycleCheck,
                                      horizontalCheckInterlock, stepperGo,
                                      commandRequest, biDirectionalMode, 1'b0};
        ADDR_DEVADDR: avsReaddata <= {24'h000000, deviceAddress};
        default:      avsReaddata <= READ_UNMAPPED;
      endcase
    end else begin
      avsWaitrequest <= 1'b1;
    end
  end

  assign irq = |(eventStatus & eventMask);

endmodule

// *** tb/printer_partner.sv ***
module printer_partner
  import printer_attach_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       answer,
  input  wire logic [3:0] slowness,
  input  wire logic       trigA,
  input  wire logic       trigB,
  output logic [3:0]      clockPhase,
  output logic            stepperEmitter
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Processor phase clock and printer emitter echo
  // --------------------------------------------------------------------------
  logic [1:0] lastTr;
  logic [7:0] cnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clockPhase <= 4'h0;
    end else begin
      clockPhase <= (clockPhase == PHASE_LAST) ? 4'h0 : clockPhase + 4'h1;
    end
  end

  // While answer is high, each trigger change is echoed by one emitter pulse after a settable delay.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lastTr <= 2'h0;
      cnt <= 8'h00;
      stepperEmitter <= 1'b0;
    end else if ({trigA, trigB} != lastTr) begin
      lastTr <= {trigA, trigB};
      cnt <= answer ? {slowness, 4'h8} : 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      stepperEmitter <= (cnt > 8'h01) && (cnt < 8'h06);
    end else begin
      stepperEmitter <= 1'b0;
    end
  end
endmodule

// *** tb/printer_attach_asserts.sv ***
module printer_attach_asserts
  import printer_attach_pkg::*;
(
  input wire logic                            mclk,
  input wire logic                            rst,
  input wire logic [3:0]                      clockPhase,
  input wire logic                            secondInstrCycle,
  input wire logic                            thirdInstrCycle,
  input wire logic                            firstExecuteCycle,
  input wire printer_attach_pkg::io_request_s  ioRequest,
  input wire printer_attach_pkg::sense_bytes_s senseLow,
  input wire logic                            senseUpperPair,
  input wire logic                            commandSteal,
  input wire logic                            matrixCounterTr1,
  input wire logic                            conditionAccepted,
  input wire logic                            conditionValid,
  input wire logic [7:0]                      inboundBus,
  input wire logic                            inboundValid,
  input wire logic                            biDirectionalMode,
  input wire logic                            commandRequest,
  input wire logic                            priorityRequestBit5,
  input wire logic                            stepperGo,
  input wire logic                            stepperStartPulse,
  input wire logic                            horizontalCommand,
  input wire logic                            horizontalLeftCommand,
  input wire logic                            elementReturn,
  input wire logic                            horizontalCheckInterlock,
  input wire logic                            stepperPhaseATrigger,
  input wire logic                            stepperPhaseBTrigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] trig;
  assign trig = {stepperPhaseATrigger, stepperPhaseBTrigger};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence sAsk;
    ioRequest.startIo && secondInstrCycle;
  endsequence
  sequence sBad;
    sAsk ##0 (!ioRequest.parityOk || ioRequest.modifier > MOD_MAX
      || ioRequest.deviceAddr != DEVICE_ADDR_DEFAULT);
  endsequence
  a_cond_answer: assert property (sAsk |=> conditionValid)
    else $error("condition code missing");
  a_start_refused: assert property (sBad |=> conditionValid && !conditionAccepted)
    else $error("bad start accepted");
  a_bidir_at_5c: assert property ($rose(biDirectionalMode) |-> $past(clockPhase) == PHASE_5C)
    else $error("print mode latch off phase");
  a_cmdreq_at_7b: assert property ($rose(commandRequest) |-> $past(clockPhase) == PHASE_7B
    && $past(thirdInstrCycle)) else $error("command request off phase");
  a_prio_at_6: assert property ($rose(priorityRequestBit5) |-> $past(commandRequest)
    && $past(clockPhase) == PHASE_6) else $error("priority bit off phase");
  a_go_fires_pulse: assert property ($rose(stepperGo) |-> $past(clockPhase) == PHASE_6
    && $past(commandSteal) ##[0:2] stepperStartPulse) else $error("start pulse missing");
  a_elem_cmds: assert property ($rose(elementReturn) |-> horizontalCommand
    && horizontalLeftCommand && $past(clockPhase) == PHASE_5C) else $error("return cmds");
  a_sense_low: assert property (firstExecuteCycle && ioRequest.senseIo && !senseUpperPair
    |=> inboundValid && inboundBus == senseLow.status1) else $error("sense byte wrong");
  a_step_one_bit: assert property ($changed(trig) |-> (trig ^ $past(trig)) inside
    {2'b01, 2'b10}) else $error("two triggers moved");
  a_inlk_clears: assert property ($rose(matrixCounterTr1) && horizontalCheckInterlock
    |-> ##[1:6] !horizontalCheckInterlock) else $error("interlock stuck");
endmodule

bind printer_attachment_start_and_stepper printer_attach_asserts u_chk (
  .mclk, .rst, .clockPhase, .secondInstrCycle, .thirdInstrCycle, .firstExecuteCycle,
  .ioRequest, .senseLow, .senseUpperPair, .commandSteal, .matrixCounterTr1,
  .conditionAccepted, .conditionValid, .inboundBus, .inboundValid, .biDirectionalMode,
  .commandRequest, .priorityRequestBit5, .stepperGo, .stepperStartPulse, .horizontalCommand,
  .horizontalLeftCommand, .elementReturn, .horizontalCheckInterlock, .stepperPhaseATrigger,
  .stepperPhaseBTrigger
);

// *** tb/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import printer_attach_pkg::*;
  logic mclk, rst, secondInstrCycle, thirdInstrCycle, firstExecuteCycle, laterExecuteCycle;
  logic senseUpperPair, commandSteal, stepperEmitter, matrixCounterTr1, avsRead, avsWrite;
  logic conditionAccepted, conditionValid, inboundValid, biDirectionalMode, setCommandRequest;
  logic commandRequest, priorityRequestBit5, stepperGo, stepperStartPulse, horizontalCommand;
  logic horizontalLeftCommand, elementReturn, horizontalCheckInterlock, horizontalCycleCheck;
  logic stepperPhaseATrigger, stepperPhaseBTrigger, avsWaitrequest, irq, answer, seenAcc, seenVal;
  logic [3:0]   clockPhase, avsAddress, slowness;
  logic [7:0]   inboundBus;
  logic [8:0]   grab;
  logic [31:0]  avsWritedata, avsReaddata, rd;
  io_request_s  ioRequest;
  sense_bytes_s senseLow, senseHigh;
  int err_total, compares;

  printer_attachment_start_and_stepper u_dut (.*);
  printer_partner u_far (.mclk, .rst, .answer, .slowness, .trigA(stepperPhaseATrigger),
    .trigB(stepperPhaseBTrigger), .clockPhase, .stepperEmitter);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Holds one processor cycle kind over a full phase sweep 0..8.
  task automatic sweep(input int which);
    do @(posedge mclk); while (clockPhase !== PHASE_LAST);
    case (which)
      2: secondInstrCycle <= 1'b1;
      3: thirdInstrCycle <= 1'b1;
      4: firstExecuteCycle <= 1'b1;
      5: laterExecuteCycle <= 1'b1;
      default: commandSteal <= 1'b1;
    endcase
    {seenAcc, seenVal} = 2'b00;
    for (int k = 0; k < 9; k++) begin
      @(posedge mclk);
      if (k == 1) grab = {inboundValid, inboundBus};
      if (k > 0) seenAcc |= conditionAccepted;
      if (k > 0) seenVal |= conditionValid;
    end
    {secondInstrCycle, thirdInstrCycle, firstExecuteCycle, laterExecuteCycle} <= 4'h0;
    commandSteal <= 1'b0;
  endtask

  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] wd);
    avsAddress <= a;
    avsWritedata <= wd;
    if (w) avsWrite <= 1'b1;
    else avsRead <= 1'b1;
    do @(posedge mclk); while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    {avsRead, avsWrite} <= 2'b00;
    @(posedge mclk);
  endtask

  function automatic logic [1:0] nxt(input logic [1:0] t, input logic fwd);
    nxt = ((t[1] == t[0]) == fwd) ? {~t[1], t[0]} : {t[1], ~t[0]};
  endfunction
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs;
    avs(1'b0, ADDR_DEVADDR, 32'h0);
    check(rd, {24'h000000, DEVICE_ADDR_DEFAULT});
    avs(1'b1, 4'hF, 32'hFFFFFFFF);
    avs(1'b0, 4'hF, 32'h0);
    check(rd, READ_UNMAPPED);
    avs(1'b0, ADDR_MASK, 32'h0);
    check(rd, 32'h00000000);
  endtask

  task automatic t_reject;
    for (int k = 0; k < 3; k++) begin
      ioRequest <= '{1'b1, 1'b0, DEVICE_ADDR_DEFAULT ^ {7'h00, k == 1},
        (k == 2) ? 3'h4 : MOD_PRINT, 8'h00, k != 0};
      sweep(2);
      check({seenVal, seenAcc}, 2'b10);
    end
  endtask

  task automatic run_op(input logic [2:0] md, input logic bit7, input logic fwd);
    logic [1:0] prev;
    int n, rises;
    ioRequest <= '{1'b1, 1'b0, DEVICE_ADDR_DEFAULT, md, {bit7, 7'h00}, 1'b1};
    sweep(2);
    check({seenVal, seenAcc}, 2'b11);
    sweep(3);
    check(biDirectionalMode, bit7);
    check({commandRequest, setCommandRequest}, 2'b11);
    ioRequest.startIo <= 1'b0;
    n = 0;
    while (priorityRequestBit5 !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    check(priorityRequestBit5, 1'b1);
    sweep(6);
    check({elementReturn, horizontalCommand, horizontalLeftCommand},
      (md == MOD_ELEM_RET) ? 3'b111 : 3'b010);
    check({stepperGo, stepperStartPulse, horizontalCheckInterlock, horizontalCycleCheck},
      4'b1110);
    for (int s = 0; s < 4; s++) begin
      prev = {stepperPhaseATrigger, stepperPhaseBTrigger};
      n = 0;
      rises = 0;
      while ({stepperPhaseATrigger, stepperPhaseBTrigger} === prev && n < 900) begin
        @(posedge mclk);
        n++;
        if (stepperEmitter === 1'b1 && u_far.cnt == 8'h04) rises++;
      end
      check({stepperPhaseATrigger, stepperPhaseBTrigger}, nxt(prev, fwd));
      if (s > 0) check(rises, 1);
    end
    matrixCounterTr1 <= 1'b1;
    repeat (3) @(posedge mclk);
    matrixCounterTr1 <= 1'b0;
    repeat (6) @(posedge mclk);
    check(horizontalCheckInterlock, 1'b0);
  endtask

  task automatic t_sense;
    for (int u = 0; u < 2; u++) begin
      senseUpperPair <= u[0];
      ioRequest <= '{1'b0, 1'b1, DEVICE_ADDR_DEFAULT, MOD_PRINT, 8'h00, 1'b1};
      sweep(4);
      check(grab, {1'b1, u ? senseHigh.status1 : senseLow.status1});
      sweep(5);
      check(grab, {1'b1, u ? senseHigh.status2 : senseLow.status2});
    end
    ioRequest.senseIo <= 1'b0;
  endtask

  task automatic t_irq;
    logic a;
    answer <= 1'b0;
    repeat (1200) @(posedge mclk);
    avs(1'b0, ADDR_STATUS, 32'h0);
    check({rd[EVT_REJECT], rd[EVT_ACCEPT]}, 2'b11);
    avs(1'b1, ADDR_MASK, 32'h0);
    a = irq;
    avs(1'b1, ADDR_MASK, 32'hF);
    check(irq ^ a, 1'b1);
    avs(1'b1, ADDR_STATUS, 32'hF);
    check(irq, 1'b0);
    avs(1'b1, ADDR_MASK, 32'h0);
    check(irq, 1'b0);
  endtask
  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    {secondInstrCycle, thirdInstrCycle, firstExecuteCycle, laterExecuteCycle} = 4'h0;
    {senseUpperPair, commandSteal, matrixCounterTr1, avsRead, avsWrite} = 5'h00;
    {avsAddress, avsWritedata, err_total, compares} = '0;
    ioRequest = '0;
    senseLow = '{8'hA5, 8'h3C};
    senseHigh = '{8'h96, 8'h0F};
    answer = 1'b1;
    slowness = 4'h0;
    rst = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_reject();
    run_op(MOD_TAB_RIGHT, 1'b0, 1'b1);
    slowness <= 4'hA;
    run_op(MOD_ELEM_RET, 1'b1, 1'b0);
    t_sense();
    t_irq();
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    $display("watchdog expired at %0t", $time);
    end_sim();
  end
endmodule
